// ==== rsc_pkg.sv ====
package rsc_pkg;

  // register indices (byte offset is index times four, from avs_address_i[5:2])
  localparam logic [3:0] RSC_IDX_CAUSE   = 4'h0;
  localparam logic [3:0] RSC_IDX_SWTRIG  = 4'h1;
  localparam logic [3:0] RSC_IDX_UNLOCK  = 4'h2;
  localparam logic [3:0] RSC_IDX_STATUS  = 4'h3;

  // cause flag bit positions
  localparam int RSC_BIT_POWERUP   = 0;
  localparam int RSC_BIT_BROWNOUT  = 1;
  localparam int RSC_BIT_PIN       = 2;
  localparam int RSC_BIT_WATCHDOG  = 3;
  localparam int RSC_BIT_SOFT      = 4;
  localparam int RSC_BIT_DEBUG     = 5;
  localparam int RSC_NUM_SRC       = 6;
  localparam int RSC_BIT_SOFTRST   = 0;

  // reset values and keys
  localparam logic [5:0] RSC_CAUSE_RST    = 6'h00;
  localparam logic [7:0] RSC_IO_KEY       = 8'hD8;
  localparam logic [2:0] RSC_UNLOCK_WIN   = 3'h4;
  localparam logic [1:0] RSC_PIN_ENABLED  = 2'h1;

  // timing
  localparam int RSC_CLK_MHZ        = 125;
  localparam int RSC_PIN_FILT_NS    = 2000;
  localparam int RSC_PIN_FILT_CYC   = (RSC_PIN_FILT_NS * RSC_CLK_MHZ + 999) / 1000;
  localparam int RSC_INIT_CYC       = 16;
  localparam int RSC_SUT_UNIT_CYC   = 1024;

  typedef enum logic [1:0] {
    RSC_ST_HOLD,
    RSC_ST_INIT,
    RSC_ST_CRC,
    RSC_ST_RUN
  } rsc_state_t;

  // fuse bundle
  typedef struct packed {
    logic [1:0] pin_function_field;
    logic       boot_crc_field;
    logic [2:0] startup_delay_field;
    logic [2:0] brownout_fuse;
  } rsc_fuse_t;

  // reset domain outputs
  typedef struct packed {
    logic brownout_cfg_rst;
    logic fuse_reload;
    logic debug_link_rst;
    logic volatile_rst;
  } rsc_domain_t;

endpackage

// ==== rsc_reset_unit.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - latch the causing source in cause flags
// - sources split into supply and user classes
// - hold reset while supply low, until init done
// - supply drop reasserts reset at once
// - brown-out holds reset until supply recovers
// - brown-out level comes from fuse only
// - pin reset only after filtered low time
// - pin acts only when fuse field enables
// - pin holds reset while low
// - watchdog timeout request causes reset
// - bit 0 write at index 1 resets
// - soft reset starts immediately after write
// - debug link reset only from supply resets
// - supply resets clear all domains
// - user resets spare brown-out cfg and debug
// - init after release, plus startup after supply
// - boot crc extends init until scan done
// - works in active and all sleep modes
// - unkeyed write is ignored, no reset
// - trigger register needs io unlock key
// - flags bits five to zero, upper zero
// - write one clears a flag
// - supply resets clear lower-priority flags
// - trigger bit always reads zero
// - program counter zero after any reset
module rsc_reset_unit
  import rsc_pkg::*;
#(
  parameter int SUT_UNIT_CYC = RSC_SUT_UNIT_CYC
) (
  // clock and bus-logic reset
  input  wire logic               clk_sys_i,
  input  wire logic               resetn_i,
  // avalon-mm slave
  input  wire logic [5:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  input  wire logic [3:0]         avs_byteenable_i,
  output logic [31:0]             avs_readdata_o,
  output logic                    avs_waitrequest_o,
  // reset sources
  input  wire logic               powerup_low_i,
  input  wire logic               brownout_detect_i,
  input  wire logic               pin_resetn_i,
  input  wire logic               watchdog_timeout_i,
  input  wire logic               debug_link_req_i,
  input  wire logic               memory_crc_done_i,
  input  wire rsc_pkg::rsc_fuse_t fuse_i,
  // reset outputs
  output logic                    sys_reset_o,
  output rsc_pkg::rsc_domain_t    domain_o,
  output logic [2:0]              brownout_level_o,
  output logic                    memory_crc_start_o,
  output logic                    pc_clear_o
);

  import rsc_pkg::*;

  localparam logic [7:0] FILT_MAX = 8'(RSC_PIN_FILT_CYC);

  //////////////////////////////////////////////////////////////////////////
  // input synchronisers (pin and async detectors)
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] raw_in;
  assign raw_in = {debug_link_req_i, watchdog_timeout_i, ~pin_resetn_i,
                   brownout_detect_i, powerup_low_i};

  // two stages before any logic reads them
  always_ff @(posedge clk_sys_i) begin
    sync1_reg <= raw_in;
    sync2_reg <= sync1_reg;
  end

  logic por_s, bod_s, pin_low_s, wdt_s, dbg_s;
  assign por_s     = sync2_reg[0];
  assign bod_s     = sync2_reg[1];
  assign pin_low_s = sync2_reg[2];
  assign wdt_s     = sync2_reg[3];
  assign dbg_s     = sync2_reg[4];

  //////////////////////////////////////////////////////////////////////////
  // pin noise filter
  logic [7:0] filt_reg;
  logic       pin_req_reg;
  logic       pin_en;
  assign pin_en = (fuse_i.pin_function_field == RSC_PIN_ENABLED);

  // short low pulses restart the count and never reach the request
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || !pin_low_s || !pin_en) begin
      filt_reg    <= 8'h00;
      pin_req_reg <= 1'b0;
    end else if (filt_reg < FILT_MAX) begin
      filt_reg <= filt_reg + 8'h01;
    end else begin
      pin_req_reg <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register bus: one-cycle answer via waitrequest
  logic       ack_reg;
  logic       bus_req;
  logic [3:0] idx;
  assign bus_req = (avs_read_i || avs_write_i) && !ack_reg;
  assign idx     = avs_address_i[5:2];
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  logic wr_hit;
  assign wr_hit = avs_write_i && ack_reg && avs_byteenable_i[0];

  //////////////////////////////////////////////////////////////////////////
  // change protection: key opens a short window
  logic [2:0] unlock_reg;
  logic       soft_req;
  logic       key_wr;
  assign key_wr   = wr_hit && (idx == RSC_IDX_UNLOCK) &&
                    (avs_writedata_i[7:0] == RSC_IO_KEY);
  // unkeyed trigger write is simply dropped
  assign soft_req = wr_hit && (idx == RSC_IDX_SWTRIG) && (unlock_reg != 3'h0) &&
                    avs_writedata_i[RSC_BIT_SOFTRST];

  // window counts clk_sys_i cycles as a stand-in for instructions
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      unlock_reg <= 3'h0;
    end else if (key_wr) begin
      unlock_reg <= RSC_UNLOCK_WIN;
    end else if (wr_hit && idx == RSC_IDX_SWTRIG) begin
      unlock_reg <= 3'h0;
    end else if (unlock_reg != 3'h0) begin
      unlock_reg <= unlock_reg - 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // source combination and classes
  logic supply_act, user_act, soft_hold_reg;
  assign supply_act = por_s || bod_s;
  assign user_act   = pin_req_reg || wdt_s || dbg_s || soft_hold_reg;

  // soft request captured at once, released after the next cycle
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      soft_hold_reg <= 1'b0;
    end else begin
      soft_hold_reg <= soft_req;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer
  rsc_state_t state_reg;
  logic       supply_seen_reg;
  logic [15:0] cnt_reg;
  logic [15:0] init_len;
  assign init_len = 16'(RSC_INIT_CYC) +
                    (supply_seen_reg ? 16'(SUT_UNIT_CYC * fuse_i.startup_delay_field)
                                     : 16'h0000);

  // detector inputs win over any stage, so reset reasserts without delay
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_reg       <= RSC_ST_HOLD;
      cnt_reg         <= 16'h0000;
      supply_seen_reg <= 1'b1;
    end else if (supply_act || user_act) begin
      state_reg <= RSC_ST_HOLD;
      cnt_reg   <= 16'h0000;
      if (supply_act) begin
        supply_seen_reg <= 1'b1;
      end
    end else begin
      unique case (state_reg)
        RSC_ST_HOLD: begin
          state_reg <= RSC_ST_INIT;
          cnt_reg   <= 16'h0000;
        end
        RSC_ST_INIT: begin
          if (cnt_reg >= init_len) begin
            state_reg <= fuse_i.boot_crc_field ? RSC_ST_CRC : RSC_ST_RUN;
            supply_seen_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        RSC_ST_CRC: begin
          if (memory_crc_done_i) begin
            state_reg <= RSC_ST_RUN;
          end
        end
        RSC_ST_RUN: begin
          state_reg <= RSC_ST_RUN;
        end
      endcase
    end
  end

  logic in_reset;
  assign in_reset = supply_act || user_act || (state_reg != RSC_ST_RUN);

  // release is registered on clk_sys_i
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sys_reset_o        <= 1'b1;
      domain_o           <= 4'hF;
      memory_crc_start_o <= 1'b0;
      pc_clear_o         <= 1'b1;
    end else begin
      sys_reset_o                  <= in_reset;
      pc_clear_o                   <= in_reset;
      domain_o.volatile_rst        <= in_reset;
      // a source arriving during the scan must still reload the fuses
      domain_o.fuse_reload         <= in_reset && (state_reg != RSC_ST_CRC ||
                                                   supply_act || user_act);
      domain_o.brownout_cfg_rst    <= supply_act;
      domain_o.debug_link_rst      <= supply_act;
      memory_crc_start_o           <= (state_reg == RSC_ST_CRC) && !supply_act && !user_act;
    end
  end

  assign brownout_level_o = fuse_i.brownout_fuse;

  //////////////////////////////////////////////////////////////////////////
  // cause flags: set wins over clear
  logic [5:0] cause_reg;
  logic [5:0] cause_set;
  logic [5:0] cause_clr;
  logic       rst_edge;
  logic       prev_rst_reg;
  assign rst_edge = in_reset && !prev_rst_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      prev_rst_reg <= 1'b0;
    end else begin
      prev_rst_reg <= in_reset;
    end
  end

  assign cause_set = {dbg_s, soft_hold_reg, wdt_s, pin_req_reg, bod_s, por_s};
  assign cause_clr = (wr_hit && idx == RSC_IDX_CAUSE) ? avs_writedata_i[5:0]
                                                       : 6'h00;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cause_reg <= RSC_CAUSE_RST;
    end else if (por_s) begin
      cause_reg <= 6'h01;
    end else if (bod_s) begin
      cause_reg <= (cause_reg & 6'h01) | 6'h02;
    end else begin
      cause_reg <= (cause_reg & ~cause_clr) | cause_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (bus_req && avs_read_i) begin
      unique case (idx)
        RSC_IDX_CAUSE:  avs_readdata_o <= {26'h0, cause_reg};
        RSC_IDX_SWTRIG: avs_readdata_o <= 32'h0000_0000;
        RSC_IDX_STATUS: avs_readdata_o <= {29'h0, (unlock_reg != 3'h0), state_reg};
        default:        avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ==== rsc_reset_unit_properties.sv ====
`timescale 1ns/100ps
module rsc_reset_unit_properties
  import rsc_pkg::*;
#(
  parameter int SUT_UNIT_CYC = RSC_SUT_UNIT_CYC
) (
  // watched ports
  input wire logic        clk_sys_i,
  input wire logic        resetn_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        powerup_low_i,
  input wire logic        brownout_detect_i,
  input wire logic        pin_resetn_i,
  input wire logic        watchdog_timeout_i,
  input wire logic        debug_link_req_i,
  input wire rsc_fuse_t   fuse_i,
  input wire logic        sys_reset_o,
  input wire rsc_domain_t domain_o,
  input wire logic [2:0]  brownout_level_o,
  input wire logic        memory_crc_start_o,
  input wire logic        pc_clear_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////////////
  // five cycles covers the two-stage sync plus the output register
  property p_por; $rose(powerup_low_i) |-> ##[1:5] sys_reset_o; endproperty
  a_por: assert property (p_por)
    else $error("supply drop did not raise reset");
  property p_pord; powerup_low_i [*5] |-> sys_reset_o; endproperty
  a_pord: assert property (p_pord)
    else $error("reset released while supply low");
  property p_bod; brownout_detect_i [*5] |-> sys_reset_o; endproperty
  a_bod: assert property (p_bod)
    else $error("reset released during brown-out");
  property p_rel;
    $fell(sys_reset_o) |-> !powerup_low_i && !brownout_detect_i && !watchdog_timeout_i
      && !debug_link_req_i && (pin_resetn_i || fuse_i.pin_function_field != RSC_PIN_ENABLED);
  endproperty
  a_rel: assert property (p_rel)
    else $error("reset released with a source active");
  property p_sup; domain_o.brownout_cfg_rst |-> domain_o.debug_link_rst && domain_o.fuse_reload;
  endproperty
  a_sup: assert property (p_sup)
    else $error("supply domain set incomplete");
  property p_crc;
    $fell(sys_reset_o) && fuse_i.boot_crc_field |-> $past(memory_crc_start_o)
      || $past(memory_crc_start_o, 2) || $past(memory_crc_start_o, 3);
  endproperty
  a_crc: assert property (p_crc)
    else $error("reset released without boot scan");
  property p_pc; pc_clear_o == sys_reset_o; endproperty
  a_pc: assert property (p_pc)
    else $error("pc clear differs from reset");
  property p_lvl; brownout_level_o == fuse_i.brownout_fuse; endproperty
  a_lvl: assert property (p_lvl)
    else $error("brown-out level not from fuse");
  property p_trig;
    avs_read_i && !avs_waitrequest_o && avs_address_i[5:2] == RSC_IDX_SWTRIG
      |-> avs_readdata_o[7:0] == 8'h00;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger register read not zero");
  property p_cause;
    avs_read_i && !avs_waitrequest_o && avs_address_i[5:2] == RSC_IDX_CAUSE
      |-> avs_readdata_o[31:6] == 26'h0;
  endproperty
  a_cause: assert property (p_cause)
    else $error("cause upper bits not zero");
endmodule

// ==== rsc_source_model.sv ====
`timescale 1ns/100ps
module rsc_source_model (
  // bench requests and scan start
  input  wire logic       clk_sys_i,
  input  wire logic [5:0] req_i,
  input  wire logic       crc_slow_i,
  input  wire logic       crc_start_i,
  // source levels
  output logic            powerup_low_o,
  output logic            brownout_o,
  output logic            pin_resetn_o,
  output logic            watchdog_o,
  output logic            debug_req_o,
  output logic            crc_done_o
);
  logic [7:0] scan_cnt_reg;
  // detector and pin levels follow the bench
  assign powerup_low_o = req_i[0];
  assign brownout_o = req_i[1];
  assign pin_resetn_o = !req_i[2];
  assign watchdog_o = req_i[3];
  assign debug_req_o = req_i[5];
  // slow scan stresses the init hold
  always_ff @(posedge clk_sys_i) begin
    scan_cnt_reg <= crc_start_i ? scan_cnt_reg + 8'h01 : 8'h00;
  end
  assign crc_done_o = crc_start_i && (scan_cnt_reg >= (crc_slow_i ? 8'h28 : 8'h01));
endmodule

// ==== tb_top.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import rsc_pkg::*;
  localparam int SUT_UNIT_CYC = 4;
  logic        clk_sys_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic        powerup_low_i, brownout_detect_i, pin_resetn_i, watchdog_timeout_i;
  logic        debug_link_req_i, memory_crc_done_i, sys_reset_o, memory_crc_start_o;
  logic        pc_clear_o, crc_slow, rst_seen;
  logic [5:0]  avs_address_i, req;
  logic [31:0] avs_writedata_i, avs_readdata_o, seed, e_h;
  logic [2:0]  brownout_level_o;
  rsc_fuse_t   fuse_i;
  rsc_domain_t domain_o;
  logic [31:0] e_q[$];
  logic [5:0]  exp_tab [6] = '{6'h01, 6'h03, 6'h04, 6'h08, 6'h10, 6'h20};
  int          err_total = 0;
  int          n_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  rsc_reset_unit #(.SUT_UNIT_CYC(SUT_UNIT_CYC)) u_dut (.clk_sys_i, .resetn_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o,
    .avs_waitrequest_o, .powerup_low_i, .brownout_detect_i, .pin_resetn_i, .watchdog_timeout_i,
    .debug_link_req_i, .memory_crc_done_i, .fuse_i, .sys_reset_o, .domain_o, .brownout_level_o,
    .memory_crc_start_o, .pc_clear_o);
  rsc_source_model u_src (.clk_sys_i, .req_i(req), .crc_slow_i(crc_slow),
    .crc_start_i(memory_crc_start_o), .powerup_low_o(powerup_low_i),
    .brownout_o(brownout_detect_i), .pin_resetn_o(pin_resetn_i), .watchdog_o(watchdog_timeout_i),
    .debug_req_o(debug_link_req_i), .crc_done_o(memory_crc_done_i));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // waitrequest sampled at the rising edge; release only after that edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= d;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    e_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) if (sys_reset_o === 1'b1) rst_seen <= 1'b1;
  // read data compared against the oldest note
  always @(posedge clk_sys_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0 && e_q.size() > 0) begin
      e_h = e_q.pop_front();
      `CHK("readdata", e_h, avs_readdata_o)
    end
  end
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    err_total++;
    end_sim();
  end
  initial begin
    {resetn_i, avs_read_i, avs_write_i, crc_slow, rst_seen} = 5'h0;
    {avs_address_i, req, avs_writedata_i} = '0;
    seed = xs(32'h09B4D13B);
    fuse_i = '{RSC_PIN_ENABLED, 1'b1, seed[2:0], seed[5:3]};
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    wait (sys_reset_o === 1'b0);
    rd(6'h00, 32'h0);
    rd(6'h04, 32'h0);
    rd(6'h10, 32'h0);
    rst_seen = 1'b0;
    bus(1'b1, 6'h04, 32'h1);
    // pin disabled long low, then enabled short low: neither may reset
    @(posedge clk_sys_i);
    fuse_i.pin_function_field <= 2'h0;
    req <= 6'h04;
    repeat (300) @(posedge clk_sys_i);
    req <= 6'h00;
    fuse_i.pin_function_field <= RSC_PIN_ENABLED;
    repeat (4) @(posedge clk_sys_i);
    req <= 6'h04;
    repeat (100) @(posedge clk_sys_i);
    req <= 6'h00;
    repeat (8) @(negedge clk_sys_i);
    `CHK("reset_seen", 1'b0, rst_seen)
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      crc_slow <= i[0];
      if (i == 4) begin
        bus(1'b1, 6'h08, {seed[31:8], RSC_IO_KEY});
        bus(1'b1, 6'h04, 32'h1);
        wait (sys_reset_o === 1'b1);
        @(negedge clk_sys_i);
      end else begin
        @(posedge clk_sys_i);
        req <= 6'h01 << i;
        repeat (300) @(negedge clk_sys_i);
      end
      `CHK("domain", (i < 2) ? 4'hF : 4'h5, domain_o)
      @(posedge clk_sys_i);
      req <= 6'h00;
      wait (sys_reset_o === 1'b0);
      rd(6'h00, {26'h0, exp_tab[i]});
      if (i > 0) begin
        bus(1'b1, 6'h00, {seed[31:6], ~exp_tab[i]});
        rd(6'h00, {26'h0, exp_tab[i]});
        bus(1'b1, 6'h00, 32'h3F);
        rd(6'h00, 32'h0);
      end
    end
    end_sim();
  end
endmodule
bind rsc_reset_unit rsc_reset_unit_properties #(.SUT_UNIT_CYC(SUT_UNIT_CYC)) u_props (
  .clk_sys_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_readdata_o, .avs_waitrequest_o,
  .powerup_low_i, .brownout_detect_i, .pin_resetn_i, .watchdog_timeout_i, .debug_link_req_i,
  .fuse_i, .sys_reset_o, .domain_o, .brownout_level_o, .memory_crc_start_o, .pc_clear_o);
